//--- logic/vdet_pkg.sv
// package of constants for the voltage detector mode control block
// assumes an ahb-lite slave with 32-bit words and a 250 MHz clock
package vdet_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESET_CAUSE = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_SEL = 0;
  localparam int CTRL_OUT_MASK = 1;
  localparam int CTRL_INT_MASK = 2;
  localparam int CTRL_LEVEL_SEL = 3;
  localparam int RESET_CAUSE_DET = 0;
  localparam int EV_DETECT = 0;
  localparam int EV_RESET = 1;
  localparam int EV_STABLE = 2;
  localparam int EV_COUNT = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RESET = 4'h7;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // detector modes from the option field
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_INT = 2'b01,
    MODE_INT_RESET = 2'b10,
    MODE_RESET = 2'b11
  } det_mode_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STAB_TIME_US = 400;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
  localparam int STAB_LS_CLOCKS = 5;
  localparam int RESET_PULSE_CYCLES = 4;

endpackage

//--- logic/vdet_stab_timer.sv
// stabilization wait counter, done when either the time or low-speed clocks elapse
// assumes ls_tick is a one-cycle pulse per low-speed oscillator period
`timescale 1ns/1ps
module vdet_stab_timer #(
  parameter int CYCLES = vdet_pkg::STAB_CYCLES,
  parameter int LS_CLOCKS = vdet_pkg::STAB_LS_CLOCKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic ls_tick,
  output logic busy,
  output logic done
);

  logic [31:0] cyc;
  logic [7:0] ls;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cyc <= 32'h0000_0000;
      ls <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cyc <= 32'h0000_0000;
        ls <= 8'h00;
      end else if (busy) begin
        cyc <= cyc + 32'h0000_0001;
        if (ls_tick) begin
          ls <= ls + 8'h01;
        end
        if (cyc >= 32'(CYCLES - 1) || ls >= 8'(LS_CLOCKS)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

//--- logic/vdet_ctrl.sv
// voltage detector mode control: mode decode, reset/interrupt gating, ahb-lite registers
// assumes the comparator level is synchronous to clk and the option field is static
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module vdet_ctrl #(
  parameter int STAB_CYCLES = vdet_pkg::STAB_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic below_level,
  input wire logic ls_tick,
  input wire logic detector_mode_opt_hi,
  input wire logic detector_mode_opt_lo,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic detector_interrupt,
  output logic det_reset_req,
  output logic irq
);

  logic detector_status_flag;
  logic status_q;
  logic detector_mode_select_bit;
  logic detector_output_mask_bit;
  logic detector_int_mask_flag;
  logic detector_level_select;
  logic detector_reset_cause_flag;
  logic detector_int_request_flag;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] event_set;
  logic [2:0] rst_cnt;
  logic stab_busy;
  logic stab_done;
  logic stab_start;
  logic pending_stab;
  logic det_rise;
  logic do_reset;
  logic do_int;
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic wr_ctrl;
  logic rd_status_irq;
  vdet_pkg::det_mode_t mode;

  assign mode = vdet_pkg::det_mode_t'({detector_mode_opt_hi, detector_mode_opt_lo});

  // ----------------------------------------------------------------
  // comparator sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detector_status_flag <= 1'b0;
      status_q <= 1'b0;
    end else begin
      detector_status_flag <= below_level;
      status_q <= detector_status_flag;
    end
  end

  assign det_rise = detector_status_flag && !status_q;
  // masking holds off both actions while software settles the mode
  assign do_reset = det_rise && !detector_output_mask_bit &&
    (mode == vdet_pkg::MODE_RESET ||
     (mode == vdet_pkg::MODE_INT_RESET && !detector_mode_select_bit));
  assign do_int = det_rise && !detector_output_mask_bit &&
    (mode == vdet_pkg::MODE_INT ||
     (mode == vdet_pkg::MODE_INT_RESET && detector_mode_select_bit));

  // ----------------------------------------------------------------
  // reset generation and cause
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt <= 3'h0;
      det_reset_req <= 1'b0;
    end else begin
      if (do_reset) begin
        rst_cnt <= 3'(vdet_pkg::RESET_PULSE_CYCLES);
        det_reset_req <= 1'b1;
      end else if (rst_cnt != 3'h0) begin
        rst_cnt <= rst_cnt - 3'h1;
        det_reset_req <= (rst_cnt != 3'h1);
      end
    end
  end

  // cause flag survives the detector reset; only a read clears it
  logic rd_cause;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detector_reset_cause_flag <= 1'b0;
    end else if (do_reset) begin
      detector_reset_cause_flag <= 1'b1;
    end else if (rd_cause) begin
      detector_reset_cause_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // stabilization wait after detector reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_stab <= 1'b0;
    end else begin
      pending_stab <= (rst_cnt == 3'h1) && (mode == vdet_pkg::MODE_INT_RESET);
    end
  end
  assign stab_start = pending_stab;

  vdet_stab_timer #(
    .CYCLES(STAB_CYCLES),
    .LS_CLOCKS(vdet_pkg::STAB_LS_CLOCKS)
  ) u_stab (
    .clk(clk),
    .rst_n(rst_n),
    .start(stab_start),
    .ls_tick(ls_tick),
    .busy(stab_busy),
    .done(stab_done)
  );

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  assign wr_ctrl = ph_valid && ph_write && ph_addr == vdet_pkg::OFF_CTRL;
  assign rd_status_irq = hsel && htrans[1] && !hwrite && hready && haddr[7:0] == vdet_pkg::OFF_IRQ_STATUS;
  assign rd_cause = hsel && htrans[1] && !hwrite && hready && haddr[7:0] == vdet_pkg::OFF_RESET_CAUSE;

  // mask flag is forced on by reset and by detector reset alike
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {detector_level_select, detector_int_mask_flag, detector_output_mask_bit, detector_mode_select_bit}
        <= vdet_pkg::CTRL_RESET;
    end else if (do_reset) begin
      detector_int_mask_flag <= 1'b1;
      detector_mode_select_bit <= 1'b1;
      detector_output_mask_bit <= 1'b1;
    end else if (wr_ctrl) begin
      detector_mode_select_bit <= hwdata[vdet_pkg::CTRL_MODE_SEL];
      detector_output_mask_bit <= hwdata[vdet_pkg::CTRL_OUT_MASK];
      detector_int_mask_flag <= hwdata[vdet_pkg::CTRL_INT_MASK];
      detector_level_select <= hwdata[vdet_pkg::CTRL_LEVEL_SEL];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= vdet_pkg::IRQ_MASK_RESET;
    end else if (ph_valid && ph_write && ph_addr == vdet_pkg::OFF_IRQ_MASK) begin
      irq_mask <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        vdet_pkg::OFF_CTRL: hrdata <= {28'h000_0000, detector_level_select, detector_int_mask_flag,
          detector_output_mask_bit, detector_mode_select_bit};
        vdet_pkg::OFF_STATUS: hrdata <= {27'h000_0000, stab_busy, detector_int_request_flag,
          mode, detector_status_flag};
        vdet_pkg::OFF_RESET_CAUSE: hrdata <= {31'h0000_0000, detector_reset_cause_flag};
        vdet_pkg::OFF_IRQ_STATUS: hrdata <= {29'h0000_0000, irq_status};
        vdet_pkg::OFF_IRQ_MASK: hrdata <= {29'h0000_0000, irq_mask};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // no wait states and never an error, still kept in flops so every output is registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request and sticky events
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detector_int_request_flag <= 1'b0;
      detector_interrupt <= 1'b0;
    end else begin
      if (do_int) begin
        detector_int_request_flag <= 1'b1;
      end else if (rd_status_irq) begin
        detector_int_request_flag <= 1'b0;
      end
      detector_interrupt <= do_int && !detector_int_mask_flag;
    end
  end

  assign event_set = {stab_done, do_reset, do_int};
  // set wins over a read clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (rd_status_irq ? 3'h0 : irq_status) | event_set;
      irq <= |(((rd_status_irq ? 3'h0 : irq_status) | event_set) & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // reset pulse is exactly four cycles, then drops
  sequence det_reset_pulse_s;
    det_reset_req [*4] ##1 !det_reset_req;
  endsequence

  // timer is busy two cycles after the last reset pulse cycle
  sequence stab_launch_s;
    ##2 stab_busy;
  endsequence

  AST_MASK_AFTER_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    do_reset |=> detector_int_mask_flag) else $error("mask flag not set after detector reset");
  AST_CAUSE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    do_reset |=> detector_reset_cause_flag) else $error("reset cause not recorded");
  AST_RESET_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    (det_rise && !detector_output_mask_bit && mode == vdet_pkg::MODE_RESET) |=> det_reset_pulse_s)
    else $error("reset mode did not reset");
  AST_INT_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == vdet_pkg::MODE_INT) |-> !do_reset) else $error("interrupt mode caused reset");
  AST_INT_RESET_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    (det_rise && !detector_output_mask_bit && mode == vdet_pkg::MODE_INT_RESET && detector_mode_select_bit)
    |=> detector_int_request_flag && !det_reset_req) else $error("combined mode interrupt missing");
  AST_STAB_START: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_cnt == 3'h1 && mode == vdet_pkg::MODE_INT_RESET) |-> stab_launch_s)
    else $error("stabilization wait not started");
  AST_OUT_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    detector_output_mask_bit |-> !do_reset && !do_int) else $error("masked detector acted");
  AST_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
    detector_status_flag == $past(below_level)) else $error("status flag not sampled");

endmodule

//--- sim/vdet_ctrl_test.sv
// self-checking bench for the voltage detector mode control block
// assumes vdet_pkg is compiled first; drives ahb-lite as the only master
`timescale 1ns/1ps
module vdet_ctrl_test;
  logic clk, rst_n, below_level, ls_tick, detector_mode_opt_hi, detector_mode_opt_lo;
  logic hsel, hwrite, hready, hreadyout, hresp, detector_interrupt, det_reset_req, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int fail_count, samples_checked, cycles;

  // ----------------------------------------------------------------
  // design and clock
  // ----------------------------------------------------------------
  // short wait so the cycle-count path of the stab timer is reachable
  vdet_ctrl #(.STAB_CYCLES(50)) u_vdet_ctrl (.clk(clk), .rst_n(rst_n), .below_level(below_level),
    .ls_tick(ls_tick), .detector_mode_opt_hi(detector_mode_opt_hi),
    .detector_mode_opt_lo(detector_mode_opt_lo), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .detector_interrupt(detector_interrupt),
    .det_reset_req(det_reset_req), .irq(irq));
  assign hready = hreadyout;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // option field is static, so it only changes under reset
  task automatic do_reset(input logic [1:0] m);
    rst_n <= 1'b0;
    {detector_mode_opt_hi, detector_mode_opt_lo} <= m;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0000_0000);
    chk(name, e, rd & m);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  // raise the comparator level, count reset cycles and interrupt pulses
  task automatic detect(input int exp_rst, input int exp_int);
    int nr, ni;
    nr = 0;
    ni = 0;
    below_level <= 1'b1;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (det_reset_req === 1'b1) nr++;
      if (detector_interrupt === 1'b1) ni++;
    end
    @(posedge clk);
    below_level <= 1'b0;
    chk("reset cycles", exp_rst, nr);
    chk("interrupt pulses", exp_int, ni);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_mode();
    do_reset(2'b11);
    rdchk("ctrl", vdet_pkg::OFF_CTRL, 32'h0000_000F, 32'h0000_0007);
    rdchk("cause", vdet_pkg::OFF_RESET_CAUSE, 32'h0000_0001, 32'h0000_0000);
    rdchk("irq mask", vdet_pkg::OFF_IRQ_MASK, 32'h0000_0007, 32'h0000_0000);
    rdchk("mode", vdet_pkg::OFF_STATUS, 32'h0000_0006, 32'h0000_0006);
    rdchk("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    detect(0, 0);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
    detect(4, 0);
    rdchk("ctrl forced", vdet_pkg::OFF_CTRL, 32'h0000_0006, 32'h0000_0006);
    rdchk("cause", vdet_pkg::OFF_RESET_CAUSE, 32'h0000_0001, 32'h0000_0001);
    rdchk("cause cleared", vdet_pkg::OFF_RESET_CAUSE, 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic t_int_mode();
    do_reset(2'b01);
    rdchk("ctrl", vdet_pkg::OFF_CTRL, 32'h0000_000F, 32'h0000_0007);
    rdchk("mode", vdet_pkg::OFF_STATUS, 32'h0000_0006, 32'h0000_0002);
    ahb(vdet_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0001);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
    detect(0, 1);
    settle();
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    @(posedge clk);
    rdchk("irq status", vdet_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
    settle();
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    @(posedge clk);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0004);
    detect(0, 0);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0002);
    detect(0, 0);
    do_reset(2'b00);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
    detect(0, 0);
  endtask

  // one detector reset in combined mode, stab wait ended by ticks or by count
  task automatic int_reset_round(input logic use_ticks);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
    detect(4, 0);
    rdchk("ctrl forced", vdet_pkg::OFF_CTRL, 32'h0000_0007, 32'h0000_0007);
    rdchk("cause", vdet_pkg::OFF_RESET_CAUSE, 32'h0000_0001, 32'h0000_0001);
    rdchk("stab busy", vdet_pkg::OFF_STATUS, 32'h0000_0010, 32'h0000_0010);
    if (use_ticks) begin
      repeat (5) begin
        ls_tick <= 1'b1;
        @(posedge clk);
        ls_tick <= 1'b0;
        repeat (3) @(posedge clk);
      end
    end else begin
      repeat (60) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    rdchk("stab done", vdet_pkg::OFF_STATUS, 32'h0000_0010, 32'h0000_0000);
    rdchk("events", vdet_pkg::OFF_IRQ_STATUS, 32'h0000_0006, 32'h0000_0006);
    // mode-select cleared with the output mask still up
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0002);
  endtask

  task automatic t_int_reset_mode();
    do_reset(2'b10);
    rdchk("mode", vdet_pkg::OFF_STATUS, 32'h0000_0006, 32'h0000_0004);
    ahb(vdet_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0007);
    ahb(vdet_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
    detect(0, 1);
    rdchk("irq status", vdet_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
    int_reset_round(1'b1);
    int_reset_round(1'b0);
    detect(0, 0);
  endtask

  initial begin
    rst_n = 1'b0;
    below_level = 1'b0;
    ls_tick = 1'b0;
    detector_mode_opt_hi = 1'b1;
    detector_mode_opt_lo = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    t_reset_mode();
    t_int_mode();
    t_int_reset_mode();
    finish_test();
  end
endmodule
